/* File: rtl/stx_exec.sv */
// Execution unit for skip, table read, nibble swap and exclusive-OR ops.
// Assumes the fetch pipeline holds issue until ready and honours flush.
//
// Behaviour
// - Swap-to-accumulator puts operand nibbles crosswise in accumulator; memory, flags kept.
// - Skip-if-zero skips next instruction when byte is zero: 2 cycles, else 1.
// - A taken skip flushes the prefetched instruction and adds one dummy cycle.
// - Copy-then-skip loads byte into accumulator, skips when zero, flags kept.
// - Bit test skips, taking two cycles, only when the chosen bit is zero.
// - Current-page table read stores low ROM byte from current page into memory.
// - Last-page table read stores low ROM byte from final page into memory.
// - Both table reads load high ROM byte into the high latch, flags kept.
// - Accumulator XOR memory goes to accumulator, updating only zero flag.
// - XOR into memory writes result to memory byte, updating only zero flag.
// - Immediate XOR goes to accumulator, updating only zero flag.
`timescale 1ns/1ps
`include "stx_params.svh"
module stx_exec
	import stx_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        issue_valid,
	output logic             issue_ready,
	input  wire stx_op_t     issue_op,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic [7:0]  literal,
	input  wire logic [2:0]  bit_sel,
	input  wire logic [7:0]  table_pointer,
	input  wire logic [11:0] pc,
	output logic [11:0]      rom_addr,
	output logic             rom_read,
	input  wire logic [15:0] rom_data,
	output logic             mem_we,
	output logic [7:0]       mem_wdata,
	output logic             flush,
	output logic [7:0]       acc,
	output logic             zero_flag,
	output logic [7:0]       table_high_latch,
	output logic             busy
);
	////////////////////////////////////////////////////////////////
	stx_alu_if alu_bus ();
	stx_alu u_alu (.a(alu_bus));

	stx_state_t state;
	stx_state_t next_state;
	logic [7:0] next_acc;
	logic       next_zero;
	logic [7:0] next_tbh;
	logic       next_mem_we;
	logic [7:0] next_mem_wdata;
	logic       next_flush;
	logic [11:0] next_rom_addr;
	logic       take;

	// Last page is the top page of a 4K program ROM
	function automatic logic [11:0] table_addr(input logic last, input logic [11:0] cur_pc,
		input logic [7:0] ptr);
		table_addr = last ? {`STX_LAST_PAGE, ptr} : {cur_pc[11:8], ptr};
	endfunction : table_addr

	// Ready is combinational so a refusal is seen in the same cycle
	assign alu_bus.op      = issue_op;
	assign alu_bus.acc     = acc;
	assign alu_bus.mem     = mem_rdata;
	assign alu_bus.lit     = literal;
	assign alu_bus.bit_sel = bit_sel;
	assign issue_ready = (state == STX_ST_EXEC);
	assign take        = issue_valid && issue_ready;
	assign rom_read    = (state == STX_ST_ROM);
	assign busy        = (state != STX_ST_EXEC);

	////////////////////////////////////////////////////////////////
	// Skip overrides the table branch; no opcode asks for both
	// Memory writes reuse the core's held address, none is carried here
	always_comb
	begin
		next_state     = state;
		next_acc       = acc;
		next_zero      = zero_flag;
		next_tbh       = table_high_latch;
		next_mem_we    = 1'b0;
		next_mem_wdata = mem_wdata;
		next_flush     = 1'b0;
		next_rom_addr  = rom_addr;
		case (state)
			STX_ST_EXEC:
				if (take)
				begin
					case (issue_op)
						STX_OP_SWAP_ACC, STX_OP_COPY_SKIP_ZERO:
							next_acc = alu_bus.result;
						STX_OP_XOR_ACC, STX_OP_XOR_IMM:
						begin
							next_acc  = alu_bus.result;
							next_zero = alu_bus.is_zero;
						end
						STX_OP_XOR_MEM:
						begin
							next_mem_we    = 1'b1;
							next_mem_wdata = alu_bus.result;
							next_zero      = alu_bus.is_zero;
						end
						STX_OP_TABLE_CUR, STX_OP_TABLE_LAST:
						begin
							next_rom_addr = table_addr(issue_op == STX_OP_TABLE_LAST,
								pc, table_pointer);
							next_state = STX_ST_ROM;
						end
						default: next_state = STX_ST_EXEC;
					endcase
					if (alu_bus.skip)
					begin
						next_flush = 1'b1;
						next_state = STX_ST_DUMMY;
					end
				end
			STX_ST_ROM:
			begin
				next_mem_we    = 1'b1;
				next_mem_wdata = rom_data[7:0];
				next_tbh       = rom_data[15:8];
				next_state     = STX_ST_EXEC;
			end
			STX_ST_DUMMY: next_state = STX_ST_EXEC;
			default:      next_state = STX_ST_EXEC;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state            <= STX_ST_EXEC;
			acc              <= `STX_ACC_RST;
			zero_flag        <= `STX_ZERO_RST;
			table_high_latch <= `STX_TBH_RST;
			mem_we           <= 1'b0;
			mem_wdata        <= 8'h00;
			flush            <= 1'b0;
			rom_addr         <= 12'h000;
		end
		else
		begin
			state            <= next_state;
			acc              <= next_acc;
			zero_flag        <= next_zero;
			table_high_latch <= next_tbh;
			mem_we           <= next_mem_we;
			mem_wdata        <= next_mem_wdata;
			flush            <= next_flush;
			rom_addr         <= next_rom_addr;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks; zero flag must survive every op except the three XORs
	chk_swap_nibbles: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_SWAP_ACC |=> acc == {$past(mem_rdata[3:0]),
		$past(mem_rdata[7:4])} && !mem_we && $stable(zero_flag))
		else $error("swap result wrong");
	chk_skip_zero: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_SKIP_ZERO && mem_rdata == 8'h00 |=> flush && busy
		##1 issue_ready)
		else $error("zero skip not two cycles");
	chk_no_skip: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_SKIP_ZERO && mem_rdata != 8'h00 |=> !flush && issue_ready)
		else $error("nonzero byte skipped");
	chk_copy_skip: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_COPY_SKIP_ZERO |=> acc == $past(mem_rdata)
		&& flush == ($past(mem_rdata) == 8'h00) && $stable(zero_flag))
		else $error("copy skip wrong");
	chk_bit_skip: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_SKIP_BIT_ZERO |=> flush == !$past(mem_rdata[bit_sel]))
		else $error("bit skip wrong");
	chk_table_page: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_TABLE_LAST |=> rom_read && rom_addr[11:8] == `STX_LAST_PAGE)
		else $error("last page address wrong");
	chk_table_load: assert property (@(posedge clk) disable iff (rst)
		rom_read |=> mem_we && mem_wdata == $past(rom_data[7:0])
		&& table_high_latch == $past(rom_data[15:8]) && $stable(zero_flag) && issue_ready)
		else $error("table load wrong");
	chk_xor_mem: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_XOR_MEM |=> mem_we && $stable(acc)
		&& mem_wdata == ($past(acc) ^ $past(mem_rdata)) && zero_flag == (mem_wdata == 8'h00))
		else $error("xor into memory wrong");
	chk_xor_imm: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_XOR_IMM |=> acc == ($past(acc) ^ $past(literal))
		&& zero_flag == (acc == 8'h00))
		else $error("immediate xor wrong");
	cov_skip: cover property (@(posedge clk) disable iff (rst) flush);
	cov_table: cover property (@(posedge clk) disable iff (rst) rom_read ##1 mem_we);
	cov_xor_zero: cover property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_XOR_ACC ##1 zero_flag);
	// Remaining ops and the dummy cycle itself
	chk_xor_acc: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_XOR_ACC |=> acc == ($past(acc) ^ $past(mem_rdata))
		&& zero_flag == (acc == 8'h00) && !mem_we)
		else $error("accumulator xor wrong");
	chk_table_cur: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_TABLE_CUR |=> rom_read
		&& rom_addr == {$past(pc[11:8]), $past(table_pointer)})
		else $error("current page address wrong");
	chk_table_cycles: assert property (@(posedge clk) disable iff (rst)
		take && (issue_op == STX_OP_TABLE_CUR || issue_op == STX_OP_TABLE_LAST)
		|=> !issue_ready && !mem_we ##1 issue_ready && mem_we && !rom_read)
		else $error("table read not two cycles");
	chk_flush_pulse: assert property (@(posedge clk) disable iff (rst)
		flush |-> busy && !issue_ready ##1 !flush && issue_ready)
		else $error("skip dummy cycle wrong");
	chk_bit_keep: assert property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_SKIP_BIT_ZERO |=> $stable(acc) && $stable(zero_flag) && !mem_we)
		else $error("bit skip changed state");
	cov_bit_skip: cover property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_SKIP_BIT_ZERO ##1 flush);
	cov_last_page: cover property (@(posedge clk) disable iff (rst)
		take && issue_op == STX_OP_TABLE_LAST ##2 mem_we);
endmodule : stx_exec

/* File: shared/stx_params.svh */
// Constants for the skip, table read and exclusive-OR execution unit.
// Assumes inclusion by every design file that needs widths, the last page or reset values.
`ifndef STX_PARAMS_SVH
`define STX_PARAMS_SVH

`define STX_DATA_W       8
`define STX_ROM_AW       12
`define STX_PAGE_W       8
`define STX_LAST_PAGE    4'hF
`define STX_ACC_RST      8'h00
`define STX_ZERO_RST     1'b0
`define STX_TBH_RST      8'h00
`define STX_TABLE_CYC    2
`define STX_SKIP_CYC     2

`endif

/* File: shared/stx_pkg.sv */
// Types for the skip, table read and exclusive-OR execution unit.
// Assumes stx_params.svh is on the include path.
`include "stx_params.svh"
package stx_pkg;
	typedef enum logic [3:0] {
		STX_OP_NOP,
		STX_OP_SWAP_ACC,
		STX_OP_SKIP_ZERO,
		STX_OP_COPY_SKIP_ZERO,
		STX_OP_SKIP_BIT_ZERO,
		STX_OP_TABLE_CUR,
		STX_OP_TABLE_LAST,
		STX_OP_XOR_ACC,
		STX_OP_XOR_MEM,
		STX_OP_XOR_IMM
	} stx_op_t;

	typedef enum logic [1:0] {
		STX_ST_EXEC,
		STX_ST_ROM,
		STX_ST_DUMMY
	} stx_state_t;
endpackage : stx_pkg

/* File: shared/stx_alu_if.sv */
// Carrier between the execution unit and its combinational ALU.
// Assumes both ends import stx_pkg.
`timescale 1ns/1ps
interface stx_alu_if;
	import stx_pkg::*;
	stx_op_t     op;
	logic [7:0]  acc;
	logic [7:0]  mem;
	logic [7:0]  lit;
	logic [2:0]  bit_sel;
	logic [7:0]  result;
	logic        is_zero;
	logic        skip;
	modport core (output op, acc, mem, lit, bit_sel, input result, is_zero, skip);
	modport alu  (input op, acc, mem, lit, bit_sel, output result, is_zero, skip);
endinterface : stx_alu_if

/* File: rtl/stx_alu.sv */
// Combinational result, zero test and skip decision per opcode.
// Assumes operands are stable for the cycle that issues the op.
`timescale 1ns/1ps
module stx_alu
	import stx_pkg::*;
(
	stx_alu_if.alu a
);
	always_comb
	begin
		a.result = a.mem;
		a.skip   = 1'b0;
		case (a.op)
			STX_OP_SWAP_ACC:       a.result = {a.mem[3:0], a.mem[7:4]};
			STX_OP_SKIP_ZERO:      a.skip = (a.mem == 8'h00);
			STX_OP_COPY_SKIP_ZERO:
			begin
				a.result = a.mem;
				a.skip   = (a.mem == 8'h00);
			end
			STX_OP_SKIP_BIT_ZERO:  a.skip = ~a.mem[a.bit_sel];
			STX_OP_XOR_ACC:        a.result = a.acc ^ a.mem;
			STX_OP_XOR_MEM:        a.result = a.acc ^ a.mem;
			STX_OP_XOR_IMM:        a.result = a.acc ^ a.lit;
			default:               a.result = a.mem;
		endcase
		a.is_zero = (a.result == 8'h00);
	end
endmodule : stx_alu

/* File: testbench/skip_table_xor_instr_subset_tb_top.sv */
// Random self-checking bench for the skip, table read and XOR unit.
// Assumes stx_pkg and stx_exec are compiled first; unit asserts inside.
`timescale 1ns/1ps
`include "stx_params.svh"
module skip_table_xor_instr_subset_tb_top
	import stx_pkg::*;
;
	typedef struct {logic tbl; logic [28:0] ra; logic [28:0] v1; logic [28:0] v2;} stx_tb_exp_t;
	logic        clk, rst, issue_valid, issue_ready, rom_read, mem_we, flush, zero_flag, busy;
	stx_op_t     issue_op;
	logic [7:0]  mem_rdata, literal, table_pointer, mem_wdata, acc, table_high_latch;
	logic [2:0]  bit_sel;
	logic [11:0] pc, rom_addr;
	logic [15:0] rom_data;
	logic [31:0] seed;
	logic [7:0]  m_acc, m_wd, m_tbh;
	logic        m_z;
	logic [28:0] obs;
	int          n_fail, checks;
	stx_tb_exp_t q[$];
	stx_tb_exp_t e;
	stx_exec i_stx_exec (.clk(clk), .rst(rst), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .issue_op(issue_op), .mem_rdata(mem_rdata),
		.literal(literal), .bit_sel(bit_sel), .table_pointer(table_pointer), .pc(pc),
		.rom_addr(rom_addr), .rom_read(rom_read), .rom_data(rom_data), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .flush(flush), .acc(acc), .zero_flag(zero_flag),
		.table_high_latch(table_high_latch), .busy(busy));
	assign obs = {acc, zero_flag, flush, mem_we, mem_wdata, table_high_latch, busy, issue_ready};
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : nxt
	task automatic final_report();
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic cmp(input logic [28:0] got, input logic [28:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic clr();
		m_acc = 8'h00;
		m_z = 1'b0;
		m_wd = 8'h00;
		m_tbh = 8'h00;
	endtask : clr
	task automatic idle();
		issue_valid <= 1'b0;
		@(posedge clk);
	endtask : idle
	// Model moves at issue time; the monitor only compares snapshots
	task automatic issue(input stx_op_t op);
		stx_tb_exp_t x;
		logic [31:0] r;
		logic [15:0] rd;
		logic [7:0]  m;
		logic        skip;
		logic        we;
		r = nxt();
		rd = 16'(nxt());
		m = (r[2:0] == 3'h0) ? 8'h00 : r[15:8];
		x.tbl = (op == STX_OP_TABLE_CUR) || (op == STX_OP_TABLE_LAST);
		skip = ((op == STX_OP_SKIP_ZERO || op == STX_OP_COPY_SKIP_ZERO) && m == 8'h00)
			|| (op == STX_OP_SKIP_BIT_ZERO && !m[r[26:24]]);
		we = (op == STX_OP_XOR_MEM);
		case (op)
			STX_OP_SWAP_ACC:       m_acc = {m[3:0], m[7:4]};
			STX_OP_COPY_SKIP_ZERO: m_acc = m;
			STX_OP_XOR_ACC:        m_acc = m_acc ^ m;
			STX_OP_XOR_IMM:        m_acc = m_acc ^ r[23:16];
			STX_OP_XOR_MEM:        m_wd = m_acc ^ m;
			default:               ;
		endcase
		if (op == STX_OP_XOR_ACC || op == STX_OP_XOR_IMM)
			m_z = (m_acc == 8'h00);
		if (we)
			m_z = (m_wd == 8'h00);
		x.v1 = {m_acc, m_z, skip, we, m_wd, m_tbh, skip | x.tbl, !(skip | x.tbl)};
		x.ra = {16'h0000, 1'b1, (op == STX_OP_TABLE_LAST) ? `STX_LAST_PAGE : r[11:8], r[31:24]};
		if (x.tbl)
		begin
			m_wd = rd[7:0];
			m_tbh = rd[15:8];
		end
		x.v2 = {m_acc, m_z, 1'b0, 1'b1, m_wd, m_tbh, 1'b0, 1'b1};
		issue_op <= op;
		mem_rdata <= m;
		literal <= r[23:16];
		bit_sel <= r[26:24];
		table_pointer <= r[31:24];
		pc <= r[11:0];
		issue_valid <= 1'b1;
		@(negedge clk);
		while (issue_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		q.push_back(x);
		// ROM word must stand through the access cycle, not be overwritten by the next op
		if (x.tbl)
		begin
			rom_data <= rd;
			issue_valid <= 1'b0;
			@(posedge clk);
		end
	endtask : issue
	task automatic run(input int n);
		repeat (n)
		begin
			issue(stx_op_t'(4'(nxt() % 32'd10)));
			if (seed[1])
				idle();
		end
		repeat (3)
			idle();
	endtask : run
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Results appear one cycle after take, table data one more
	initial
	begin
		forever
		begin
			wait (q.size() > 0);
			e = q.pop_front();
			@(negedge clk);
			cmp(obs, e.v1);
			if (e.tbl)
			begin
				cmp({16'h0000, rom_read, rom_addr}, e.ra);
				@(negedge clk);
				cmp(obs, e.v2);
			end
		end
	end
	initial
	begin
		#300000;
		n_fail++;
		final_report();
	end
	initial
	begin
		rst = 1'b1;
		issue_valid = 1'b0;
		issue_op = STX_OP_NOP;
		{mem_rdata, literal, bit_sel, table_pointer, pc, rom_data} = '0;
		seed = 32'h207a;
		clr();
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		run(150);
		rst <= 1'b1;
		@(negedge clk);
		cmp(obs, 29'h1);
		clr();
		@(posedge clk);
		rst <= 1'b0;
		run(150);
		final_report();
	end
endmodule : skip_table_xor_instr_subset_tb_top
